// ---- src/prag_top.sv ----
// pc-relative address generation: decode and execute
// Overview of operation
// - destination gets word-aligned program counter plus offset
// - offsets from -4095 to +4095 bytes
// - sp or pc destination flagged invalid when the condition passes
// - condition flags never change
// - failed condition leaves destination unwritten
// - wide form gives full range, unaligned
`timescale 1ns/1ns
`default_nettype none
`include "prag_cfg.svh"
module prag_top
	import prag_pkg::*;
#(
	parameter int DW = 32 // datapath width
)(
	input wire logic clock_in, // core clock
	input wire logic resetn_in, // async reset, active low
	input wire logic ce_in, // clock enable
	input wire logic issue_in, // instruction valid
	input wire logic [31:0] insn_in, // instruction, wide: hw1 in [31:16]
	input wire logic wide_in, // 1: 32-bit encoding
	input wire logic [DW-1:0] pc_in, // program counter as read
	input wire logic [3:0] cond_in, // condition from it-block
	input wire logic [DW-1:0] flags_in, // current flag word
	output logic match_out, // instruction is this kind
	output logic wr_en_out, // register write pulse
	output logic [3:0] wr_idx_out, // destination index
	output logic [DW-1:0] wr_data_out, // computed address
	output logic [DW-1:0] flags_out, // flags passed unchanged
	output logic invalid_out, // unpredictable encoding pulse
	output logic skipped_out // condition failed pulse
);
	// narrow form: 10100 ddd iiiiiiii, offset = imm8*4 from aligned pc
	wire logic [15:0] hw0 = insn_in[15:0];
	wire logic [15:0] hw1 = insn_in[31:16];

	// narrow fields
	wire logic [4:0] n_op = hw0[15:11];
	wire logic [2:0] n_rd = hw0[10:8];
	wire logic [7:0] n_imm8 = hw0[7:0];
	wire logic n_match = !wide_in && n_op == `PRAG_N_OP16;

	// wide form: 11110 i 10 a 0 a 0 1111 / 0 iii dddd iiiiiiii
	wire logic [4:0] w_op1 = hw1[15:11];
	wire logic w_i = hw1[10];
	wire logic w_fix = hw1[9];
	wire logic [4:0] w_opc = hw1[8:4];
	wire logic [3:0] w_rn = hw1[3:0];
	wire logic w_op2 = hw0[15];
	wire logic [2:0] w_imm3 = hw0[14:12];
	wire logic [3:0] w_rd = hw0[11:8];
	wire logic [7:0] w_imm8 = hw0[7:0];

	// wide decode: add and subtract share all but the opcode bits
	wire logic w_head = w_op1 == `PRAG_W_OP1 && w_fix;
	wire logic w_sub = w_opc == `PRAG_W_SUB;
	wire logic w_add = w_opc == `PRAG_W_ADD;
	wire logic w_rn_pc = w_rn == `PRAG_PC_IDX;
	// the narrow form tops out at 1020 and is word-stepped, so the
	// wide form is the only way to the full range and odd results
	wire logic w_match = wide_in && w_head && (w_sub || w_add)
		&& w_rn_pc && w_op2 == `PRAG_W_OP2;
	wire logic is_adr = n_match || w_match;

	// offset magnitude and direction
	wire logic [11:0] w_imm = {w_i, w_imm3, w_imm8};
	wire logic [11:0] n_imm = {2'h0, n_imm8, 2'h0};
	wire logic [11:0] mag = wide_in ? w_imm : n_imm;
	wire logic neg = wide_in && w_sub;

	// destination and the two targets that must be refused
	wire logic [3:0] dst = wide_in ? w_rd : {1'b0, n_rd};
	wire logic dst_sp = dst == `PRAG_SP_IDX;
	wire logic dst_pc = dst == `PRAG_PC_IDX;
	wire logic bad_dst = dst_sp || dst_pc;

	// the pc is word-aligned first, so only the wide form yields odd
	// results; bit 0 is never forced for exchange targets
	wire logic [DW-1:0] base = {pc_in[DW-1:2], 2'h0};
	wire logic [DW-1:0] ofs = DW'(mag);

	// subtract as add of the inverted offset with carry in set
	wire logic [DW-1:0] ofs_x = neg ? ~ofs : ofs;
	wire logic [DW-1:0] carry;
	wire logic [DW-1:0] sum;
	assign carry[0] = neg;

	genvar b;
	generate
		for (b = 0; b < DW; b = b + 1) begin : g_add
			assign sum[b] = base[b] ^ ofs_x[b] ^ carry[b];
			if (b < DW - 1) begin : g_cy
				// carry out of the top bit is dropped: wraps modulo 2^DW
				assign carry[b + 1] = (base[b] & ofs_x[b])
					| (carry[b] & (base[b] ^ ofs_x[b]));
			end
		end
	endgenerate

	// condition check against the current flags
	wire logic pass;
	prag_cond_eval u_cond (
		.cond_in(cond_in),
		.nzcv_in(flags_in[`PRAG_N_BIT:`PRAG_V_BIT]),
		.pass_out(pass)
	);

	// one accepted instruction gives exactly one of three answers
	wire logic go = ce_in && issue_in && is_adr;
	wire logic take = go && pass;
	wire logic fault = take && bad_dst;
	wire logic write = take && !bad_dst;
	wire logic fail = go && !pass;

	prag_state_t st_q, st_d;
	prag_state_t st_hit;
	logic [3:0] idx_q;
	logic [DW-1:0] data_q;
	logic skip_q;

	always_comb begin
		st_hit = PRAG_ST_IDLE;
		if (fault) begin
			st_hit = PRAG_ST_FAULT;
		end else if (write) begin
			st_hit = PRAG_ST_DONE;
		end
	end

	// every answer lasts one enabled cycle, then follows the next issue
	always_comb begin
		unique case (st_q)
			PRAG_ST_IDLE: begin
				st_d = st_hit;
			end
			PRAG_ST_DONE: begin
				st_d = st_hit;
			end
			PRAG_ST_FAULT: begin
				st_d = st_hit;
			end
			default: begin
				st_d = PRAG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= PRAG_ST_IDLE;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			skip_q <= 1'b0;
		end else if (ce_in) begin
			skip_q <= fail;
		end
	end

	// refused or skipped instructions leave the last result in place
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idx_q <= 4'h0;
		end else if (ce_in && write) begin
			idx_q <= dst;
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			data_q <= '0;
		end else if (ce_in && write) begin
			data_q <= sum;
		end
	end

	// match is a level on the current inputs, not a registered answer
	assign match_out = issue_in && is_adr;

	assign wr_en_out = st_q == PRAG_ST_DONE;
	assign invalid_out = st_q == PRAG_ST_FAULT;
	assign skipped_out = skip_q;

	assign wr_idx_out = idx_q;
	assign wr_data_out = data_q;

	// flags pass straight through: nothing here computes a flag
	assign flags_out = flags_in;

endmodule
`default_nettype wire

// ---- inc/prag_cfg.svh ----
// constants for the pc-relative address generator
`ifndef PRAG_CFG_SVH
`define PRAG_CFG_SVH
`define PRAG_SP_IDX 4'hd
`define PRAG_PC_IDX 4'hf
`define PRAG_OFS_MAX 12'hfff
`define PRAG_N_OP16 5'h14
`define PRAG_W_OP1 5'h1e
`define PRAG_W_OP2 1'h0
`define PRAG_W_SUB 5'h0a
`define PRAG_W_ADD 5'h00
`define PRAG_W_TAIL 1'h1
`define PRAG_N_BIT 31
`define PRAG_Z_BIT 30
`define PRAG_C_BIT 29
`define PRAG_V_BIT 28
`endif

// ---- inc/prag_pkg.sv ----
// types for the pc-relative address generator
package prag_pkg;
	typedef enum logic [3:0] {
		PRAG_EQ, PRAG_NE, PRAG_CS, PRAG_CC, PRAG_MI, PRAG_PL, PRAG_VS,
		PRAG_VC, PRAG_HI, PRAG_LS, PRAG_GE, PRAG_LT, PRAG_GT, PRAG_LE,
		PRAG_AL, PRAG_NV
	} prag_cond_t;
	typedef enum logic [1:0] {
		PRAG_ST_IDLE, PRAG_ST_DONE, PRAG_ST_FAULT
	} prag_state_t;
endpackage

// ---- src/prag_cond_eval.sv ----
// condition code evaluation against the n, z, c, v flags
`timescale 1ns/1ns
`default_nettype none
module prag_cond_eval
	import prag_pkg::*;
(
	input wire logic [3:0] cond_in, // condition field
	input wire logic [3:0] nzcv_in, // flags n z c v
	output logic pass_out // condition holds
);
	wire n = nzcv_in[3];
	wire z = nzcv_in[2];
	wire c = nzcv_in[1];
	wire v = nzcv_in[0];
	always_comb begin
		unique case (prag_cond_t'(cond_in))
			PRAG_EQ: pass_out = z;
			PRAG_NE: pass_out = !z;
			PRAG_CS: pass_out = c;
			PRAG_CC: pass_out = !c;
			PRAG_MI: pass_out = n;
			PRAG_PL: pass_out = !n;
			PRAG_VS: pass_out = v;
			PRAG_VC: pass_out = !v;
			PRAG_HI: pass_out = c && !z;
			PRAG_LS: pass_out = !c || z;
			PRAG_GE: pass_out = n == v;
			PRAG_LT: pass_out = n != v;
			PRAG_GT: pass_out = !z && (n == v);
			PRAG_LE: pass_out = z || (n != v);
			PRAG_AL: pass_out = 1'b1;
			PRAG_NV: pass_out = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// ---- tb/prag_top_asserts.sv ----
// port assertions for prag_top
`timescale 1ns/1ns
`default_nettype none
module prag_top_asserts #(parameter int DW = 32) (
	input wire logic clock_in, resetn_in, ce_in, issue_in, wide_in,
	input wire logic [31:0] insn_in,
	input wire logic [3:0] cond_in, wr_idx_out,
	input wire logic [DW-1:0] pc_in, flags_in, wr_data_out, flags_out,
	input wire logic match_out, wr_en_out, invalid_out, skipped_out);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	wire [3:0] rd = insn_in[11:8];
	wire bad = wide_in && (rd == 4'hd || rd == 4'hf);
	wire [11:0] of = wide_in ? {insn_in[26], insn_in[14:12], insn_in[7:0]}
		: {2'h0, insn_in[7:0], 2'h0};
	wire [DW-1:0] pa = {pc_in[DW-1:2], 2'h0};
	wire [DW-1:0] ex = wide_in && insn_in[21] ? pa - of : pa + of;
	wire al = ce_in && match_out && cond_in == 4'he;
	sequence took_s; ce_in && match_out; endsequence
	sequence ans_s; wr_en_out || invalid_out || skipped_out; endsequence
	answer_a: assert property (took_s |=> ans_s)
		else $error("no result after issue");
	sum_ok_a: assert property (al && !bad |=> wr_data_out == $past(ex))
		else $error("wrong address");
	bad_dest_a: assert property (al && bad |=> invalid_out)
		else $error("sp or pc destination accepted");
	flags_same_a: assert property (flags_out == flags_in)
		else $error("flags changed");
	al_pass_a: assert property (al |=> !skipped_out)
		else $error("always condition skipped");
	one_hot_a: assert property ($onehot0({wr_en_out, invalid_out, skipped_out}))
		else $error("two results at once");
	quiet_idle_a: assert property (ce_in && !match_out |=> !ans_s)
		else $error("result without issue");
	idx_ok_a: assert property (al && !bad |=> wr_idx_out == $past(rd))
		else $error("wrong destination");
	hold_ce_a: assert property (!ce_in |=> $stable({wr_en_out, invalid_out,
		skipped_out, wr_idx_out, wr_data_out}))
		else $error("state moved while disabled");
endmodule
bind prag_top prag_top_asserts #(.DW(DW)) u_chk (.*);
`default_nettype wire

// ---- tb/pc_relative_address_gen_bench.sv ----
// random bench for prag_top against a behavioural model
`timescale 1ns/1ns
`default_nettype none
module pc_relative_address_gen_bench;
	logic clock_in = 0, resetn_in = 0, issue_in = 0, wide_in = 0, m;
	logic ce_in = 0;
	logic [31:0] ne;
	logic [3:0] nr;
	logic [2:0] nk;
	logic [31:0] insn_in = 0, pc_in = 0, flags_in = 0, o, pa, ed;
	logic [31:0] wr_data_out, flags_out;
	logic [3:0] cond_in = 0, rd, wr_idx_out;
	logic [2:0] ek = 0;
	logic match_out, wr_en_out, invalid_out, skipped_out;
	logic [15:0] lf = 16'h9f01;
	int miscompares = 0, compares = 0, cyc = 0;
	prag_top dut (.clock_in, .resetn_in, .ce_in, .issue_in, .insn_in,
		.wide_in, .pc_in, .cond_in, .flags_in, .match_out, .wr_en_out,
		.wr_idx_out, .wr_data_out, .flags_out, .invalid_out, .skipped_out);
	initial forever #5 clock_in = ~clock_in;
	always @(posedge clock_in) if (++cyc > 3000) begin
		miscompares++;
		report_and_stop();
	end
	function logic [31:0] rnd();
		for (int k = 0; k < 2; k++) begin
			lf = {1'b0, lf[15:1]} ^ (lf[0] ? 16'hb400 : 16'h0);
			rnd = {rnd[15:0], lf};
		end
	endfunction
	function logic cp(input logic [3:0] c, input logic [3:0] f);
		logic [7:0] t;
		t = {1'b1, !f[2] && f[3] == f[0], f[3] == f[0], f[1] && !f[2],
			f[0], f[3], f[1], f[2]};
		return t[c[3:1]] ^ (c[0] && c < 4'he);
	endfunction
	task chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clock_in);
		resetn_in = 1;
		for (int i = 0; i < 400; i++) begin
			@(negedge clock_in);
			chk("result", ek, {wr_en_out, invalid_out, skipped_out});
			if (ek[2]) chk("data", ed, wr_data_out);
			if (ek[2]) chk("idx", rd, wr_idx_out);
			o = rnd();
			pc_in = rnd();
			flags_in = rnd();
			if (i % 8 == 1) o[11:0] = 12'hfff; // offset range edge
			{cond_in, nr, wide_in} = o[31:23];
			issue_in = o[20] | o[19];
			ce_in = o[18] | o[17];
			m = issue_in && !(o[22] && o[21]);
			pa = {pc_in[31:2], 2'h0};
			if (wide_in) begin
				insn_in = {5'h1e, o[11], 2'h2, o[12], 1'b0, o[12], 1'b0,
					m ? 4'hf : 4'he, 1'b0, o[10:8], nr, o[7:0]};
				ne = o[12] ? pa - o[11:0] : pa + o[11:0];
			end else begin
				nr[3] = 0;
				insn_in = {16'h0, 4'ha, !m, nr[2:0], o[7:0]};
				ne = pa + {o[7:0], 2'h0};
			end
			nk = !m ? 0 : !cp(cond_in, flags_in[31:28]) ? 1
				: (nr == 4'hd || nr == 4'hf) ? 2 : 4;
			#1 chk("match", m, match_out);
			chk("flags", flags_in, flags_out);
			// disabled cycles hold every answer as it was
			if (ce_in) begin
				ek = nk;
				ed = ne;
				rd = nr;
			end
		end
		$display("random issue test done");
		report_and_stop();
	end
endmodule
`default_nettype wire
